// ---- common/serial_bus_host_pkg.sv ----
// constants, commands, states and carriers for the serial bus host
// assumes a 20 MHz system clock and an open-drain bus resolved outside
package serial_bus_host_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_MHZ         = 20;
  localparam int unsigned RESPONSE_TIMEOUT_US = 1000;
  localparam int unsigned RESPONSE_TIMEOUT_CYC = RESPONSE_TIMEOUT_US * SYS_CLK_MHZ;
  localparam logic [7:0]  FAST_RELOAD_MIN     = 8'h04;
  localparam logic [7:0]  FAST_RELOAD_DEFAULT = 8'h06;
  localparam logic [7:0]  ACK_WINDOW_DEFAULT  = 8'h40;
  localparam logic [2:0]  LAST_BIT            = 3'h7;

  // ----------------------------------------------------------------
  // commands and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_LISTEN   = 2'h0,
    CMD_TALK     = 2'h1,
    CMD_UNLISTEN = 2'h2,
    CMD_UNTALK   = 2'h3
  } bus_cmd_t;

  typedef enum logic [2:0] {
    S_IDLE    = 3'h0,
    S_ATTN    = 3'h1,
    S_FAST_LO = 3'h3,
    S_FAST_HI = 3'h2,
    S_ACK     = 3'h6,
    S_DONE    = 3'h7,
    S_ERR     = 3'h5
  } host_state_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    bus_cmd_t   kind;
    logic [7:0] addr;
  } bus_req_t;

  typedef struct packed {
    logic done;
    logic fast;
    logic timeout;
  } bus_resp_t;

  typedef struct packed {
    logic attn_low;
    logic clk_low;
    logic data_low;
  } port_bits_t;

endpackage : serial_bus_host_pkg

// ---- design/sync_2ff.sv ----
// two-stage level synchroniser, any width
// assumes each bit is a level that stays put for several clk periods
`timescale 1ns/100ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] q_d;

  always_comb begin
    meta_d = rst_b ? d : '0;
    q_d    = rst_b ? meta_q : '0;
  end

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    meta_q <= meta_d;
    q      <= q_d;
  end

endmodule : sync_2ff

// ---- design/fast_rx_link.sv ----
// fast receive shifter on the peripheral-driven fast clock
// assumes lsb first, data valid at the rising fast clock edge
`timescale 1ns/100ps
module fast_rx_link (
  input  wire logic       link_clk,
  input  wire logic       link_rst_b,
  input  wire logic       link_clr_b,
  input  wire logic       link_en,
  input  wire logic       data_in,
  output logic      [7:0] rx_byte,
  output logic            byte_tgl,
  output logic            edge_tgl
);

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] hold_d;
  logic       byte_d;
  logic       edge_d;

  // ----------------------------------------------------------------
  // shifter
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d   = cnt_q;
    shift_d = shift_q;
    hold_d  = rx_byte;
    byte_d  = byte_tgl;
    edge_d  = edge_tgl;
    if (link_en) begin
      edge_d  = ~edge_tgl;
      shift_d = {data_in, shift_q[7:1]};
      cnt_d   = cnt_q + 3'h1;
      if (cnt_q == 3'h7) begin
        // hold stays 8 edges, long enough for the far side to copy it
        hold_d = {data_in, shift_q[7:1]};
        byte_d = ~byte_tgl;
      end
    end
  end

  // link clock stands still in reset, so reset arrives as a registered level
  always_ff @(posedge link_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      rx_byte  <= 8'h00;
      byte_tgl <= 1'b0;
      edge_tgl <= 1'b0;
    end else begin
      rx_byte  <= hold_d;
      byte_tgl <= byte_d;
      edge_tgl <= edge_d;
    end
  end

  // framing restarts after each host transaction; probe and ack edges never shift in
  always_ff @(posedge link_clk or negedge link_clr_b) begin
    if (!link_clr_b) begin
      cnt_q   <= 3'h0;
      shift_q <= 8'h00;
    end else begin
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_link_byte;
    @(posedge link_clk) disable iff (!link_rst_b || !link_clr_b)
    (link_en && cnt_q == 3'h7) |=> (byte_tgl != $past(byte_tgl)) && (cnt_q == 3'h0);
  endproperty
  a_link_byte: assert property (p_link_byte)
    else $error("fast byte not completed after eighth edge");

endmodule : fast_rx_link

// ---- design/serial_bus_host.sv ----
// serial bus host: addressing, fast byte probe, speed record, isolation
// assumes open-drain pins resolved outside; fast clock wire is link clock
//
// Functional notes
// - only the host starts transactions, ordering talk or listen
// - address: pull attention low, then send one selecting address
// - give up with timeout when peripheral never answers
// - slow bits clocked by software-toggled slow clock line
// - one data line serves both speeds, bits valid with active clock
// - bus reset line resets peripherals whenever host resets
// - fast clock line unused in slow and legacy operation
// - each native-mode addressing sends fast byte: eight fast clocks, attention low
// - no acknowledge after fast byte means slow peripheral
// - speed record cleared on untalk, unlisten, error or reset
// - fast bits paced by timer, reload at least four, six typical
// - slow lines driven by plain port bits, timing from software; here attention also driven by attn_fsm, data by fast_drive
// - fast direction input isolates fast drivers from data line
// - legacy mode blocks slow bus reaching fast receive side
// - legacy mode holds fast direction at input
// - native mode cannot block both interference paths at once
`timescale 1ns/100ps
module serial_bus_host
  import serial_bus_host_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = RESPONSE_TIMEOUT_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       req_valid,
  input  wire bus_req_t   req,
  output logic            req_ready,
  output bus_resp_t       resp,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  input  wire port_bits_t port_bits,
  output logic            slow_clk_level,
  output logic            slow_data_level,
  input  wire logic       legacy_mode,
  input  wire logic [7:0] timer_reload,
  input  wire logic [7:0] ack_window,
  output logic            fast_serial_direction,
  output logic            attention_line_oe_b,
  input  wire logic       slow_clock_in,
  output logic            slow_clock_out,
  output logic            slow_clock_oe_b,
  input  wire logic       serial_data_in,
  output logic            serial_data_out,
  output logic            serial_data_oe_b,
  input  wire logic       service_request_fast_clock,
  output logic            service_request_fast_clock_out,
  output logic            service_request_fast_clock_oe_b,
  output logic            bus_reset_b
);

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  logic       clk_s;
  logic       data_s;
  logic       byte_tgl;
  logic       edge_tgl;
  logic       byte_tgl_s;
  logic       edge_tgl_s;
  logic       link_rst_b;
  logic       link_en;
  logic [7:0] link_byte;
  logic       rx_clr_b_q;

  sync_2ff #(.WIDTH(4)) u_sys_sync (
    .clk   (sys_clk),
    .rst_b (rst_b),
    .d     ({slow_clock_in, serial_data_in, byte_tgl, edge_tgl}),
    .q     ({clk_s, data_s, byte_tgl_s, edge_tgl_s})
  );

  // legacy gates the receive side off
  sync_2ff #(.WIDTH(1)) u_link_sync (
    .clk   (service_request_fast_clock),
    .rst_b (1'b1),
    .d     (~legacy_mode),
    .q     (link_en)
  );

  fast_rx_link u_rx (
    .link_clk   (service_request_fast_clock),
    .link_rst_b (link_rst_b),
    .link_clr_b (rx_clr_b_q),
    .link_en    (link_en),
    .data_in    (serial_data_in),
    .rx_byte    (link_byte),
    .byte_tgl   (byte_tgl),
    .edge_tgl   (edge_tgl)
  );

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  host_state_t state_q;
  host_state_t state_d;
  logic [31:0] tmo_q;
  logic [31:0] tmo_d;
  logic [2:0]  bit_q;
  logic [2:0]  bit_d;
  logic [7:0]  tick_q;
  logic [7:0]  tick_d;
  logic [7:0]  ackc_q;
  logic [7:0]  ackc_d;
  bus_req_t    req_q;
  bus_req_t    req_d;
  logic        fast_q;
  logic        fast_d;
  bus_resp_t   resp_d;
  logic        rx_valid_d;
  logic [7:0]  rx_data_d;
  logic        byte_last_q;
  logic        edge_last_q;
  logic        bus_reset_q;
  logic [7:0]  reload;
  logic        byte_seen;
  logic        edge_seen;
  logic        un_cmd;

  assign reload    = (timer_reload < FAST_RELOAD_MIN) ? FAST_RELOAD_MIN : timer_reload;
  assign byte_seen = byte_tgl_s != byte_last_q;
  assign edge_seen = edge_tgl_s != edge_last_q;
  assign un_cmd    = (req_q.kind == CMD_UNTALK) || (req_q.kind == CMD_UNLISTEN);
  assign req_ready = (state_q == S_IDLE);
  // registered reset level, glitch free into the link side
  assign link_rst_b = bus_reset_q;

  always_comb begin
    state_d    = state_q;
    tmo_d      = tmo_q;
    bit_d      = bit_q;
    tick_d     = tick_q;
    ackc_d     = ackc_q;
    req_d      = req_q;
    fast_d     = fast_q;
    resp_d     = '0;
    rx_valid_d = 1'b0;
    rx_data_d  = rx_data;
    case (state_q)
      S_IDLE: begin
        // only a request opens a transaction
        if (req_valid) begin
          req_d   = req;
          tmo_d   = '0;
          state_d = S_ATTN;
          if (req.kind == CMD_UNTALK || req.kind == CMD_UNLISTEN) begin
            fast_d = 1'b0;
          end
        end else if (fast_q && byte_seen) begin
          rx_valid_d = 1'b1;
          rx_data_d  = link_byte;
        end
      end
      S_ATTN: begin
        // wait for a listener under attention
        if (!data_s) begin
          tick_d  = reload;
          bit_d   = 3'h0;
          state_d = legacy_mode ? S_DONE : S_FAST_LO;
          if (legacy_mode) begin
            fast_d = 1'b0;
          end
        end else if (tmo_q == TIMEOUT_CYC - 32'd1) begin
          state_d = S_ERR;
        end else begin
          tmo_d = tmo_q + 32'd1;
        end
      end
      S_FAST_LO: begin
        if (tick_q == 8'h01) begin
          tick_d  = reload;
          state_d = S_FAST_HI;
        end else begin
          tick_d = tick_q - 8'h01;
        end
      end
      S_FAST_HI: begin
        if (tick_q == 8'h01) begin
          tick_d = reload;
          // eight clocks then listen for answer
          if (bit_q == LAST_BIT) begin
            ackc_d  = ack_window;
            state_d = S_ACK;
          end else begin
            bit_d   = bit_q + 3'h1;
            state_d = S_FAST_LO;
          end
        end else begin
          tick_d = tick_q - 8'h01;
        end
      end
      S_ACK: begin
        if (edge_seen) begin
          fast_d  = !un_cmd;
          state_d = S_DONE;
        end else if (ackc_q == 8'h00) begin
          fast_d  = 1'b0;
          state_d = S_DONE;
        end else begin
          ackc_d = ackc_q - 8'h01;
        end
      end
      S_DONE: begin
        resp_d.done = 1'b1;
        resp_d.fast = fast_q;
        state_d     = S_IDLE;
      end
      S_ERR: begin
        fast_d         = 1'b0;
        resp_d.done    = 1'b1;
        resp_d.timeout = 1'b1;
        state_d        = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q     <= S_IDLE;
      tmo_q       <= '0;
      bit_q       <= 3'h0;
      tick_q      <= 8'h00;
      ackc_q      <= 8'h00;
      req_q       <= '0;
      fast_q      <= 1'b0;
      resp        <= '0;
      rx_valid    <= 1'b0;
      rx_data     <= 8'h00;
      byte_last_q <= 1'b0;
      edge_last_q <= 1'b0;
      rx_clr_b_q  <= 1'b0;
      // peripherals held in reset with host
      bus_reset_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      tmo_q       <= tmo_d;
      bit_q       <= bit_d;
      tick_q      <= tick_d;
      ackc_q      <= ackc_d;
      req_q       <= req_d;
      fast_q      <= fast_d;
      resp        <= resp_d;
      rx_valid    <= rx_valid_d;
      rx_data     <= rx_data_d;
      byte_last_q <= byte_tgl_s;
      edge_last_q <= edge_tgl_s;
      rx_clr_b_q  <= (state_d == S_IDLE);
      bus_reset_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  logic attn_fsm;
  logic fast_drive;

  assign attn_fsm = (state_q == S_ATTN) || (state_q == S_FAST_LO) ||
                    (state_q == S_FAST_HI) || (state_q == S_ACK);
  assign fast_serial_direction = ((state_q == S_FAST_LO) || (state_q == S_FAST_HI)) && !legacy_mode;
  // fast driver only with output direction
  assign fast_drive = fast_serial_direction && !req_q.addr[bit_q];
  // native mode leaves receive path open to slow traffic
  // slow clock straight from port bits; attention adds attn_fsm, data adds fast_drive
  assign attention_line_oe_b             = !(attn_fsm || port_bits.attn_low);
  assign slow_clock_oe_b                 = !port_bits.clk_low;
  assign serial_data_oe_b                = !(port_bits.data_low || fast_drive);
  // fast clock idle outside fast byte and in legacy
  assign service_request_fast_clock_oe_b = !((state_q == S_FAST_LO) && !legacy_mode);
  assign slow_clock_out                  = 1'b0;
  assign serial_data_out                 = 1'b0;
  assign service_request_fast_clock_out  = 1'b0;
  // software reads slow clock and data back
  assign slow_clk_level  = clk_s;
  assign slow_data_level = data_s;
  assign bus_reset_b     = bus_reset_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [3:0] fast_clk_cnt_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b || state_q == S_IDLE) begin
      fast_clk_cnt_q <= 4'h0;
    end else if (state_q == S_FAST_HI && state_d == S_FAST_LO) begin
      fast_clk_cnt_q <= fast_clk_cnt_q + 4'h1;
    end else if (state_q == S_FAST_HI && state_d == S_ACK) begin
      fast_clk_cnt_q <= fast_clk_cnt_q + 4'h1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_bus_reset;
    @(posedge sys_clk) disable iff (1'b0)
    1'b1 |=> (bus_reset_b == $past(rst_b));
  endproperty
  a_bus_reset: assert property (p_bus_reset)
    else $error("bus reset does not follow host reset");

  property p_host_starts;
    (state_q == S_IDLE && !req_valid) |=> state_q == S_IDLE;
  endproperty
  a_host_starts: assert property (p_host_starts)
    else $error("transaction began without a request");

  property p_attn_low;
    (state_q == S_IDLE && req_valid) |=> !attention_line_oe_b throughout (state_q == S_ATTN)[*1];
  endproperty
  a_attn_low: assert property (p_attn_low)
    else $error("attention not asserted when addressing");

  property p_timeout;
    (state_q == S_ATTN && data_s && tmo_q == TIMEOUT_CYC - 32'd1) |=> state_q == S_ERR ##1 resp.timeout;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("missing timeout abort");

  property p_eight_clocks;
    (state_q == S_FAST_HI && state_d == S_ACK) |=> fast_clk_cnt_q == 4'h8 && !attention_line_oe_b;
  endproperty
  a_eight_clocks: assert property (p_eight_clocks)
    else $error("fast byte did not carry eight clocks");

  property p_half_period;
    $rose(state_q == S_FAST_LO) |-> (!service_request_fast_clock_oe_b || legacy_mode)[*4];
  endproperty
  a_half_period: assert property (p_half_period)
    else $error("fast clock low phase shorter than four cycles");

  property p_slow_on_silence;
    (state_q == S_ACK && ackc_q == 8'h00 && !edge_seen) |=> !fast_q ##1 (resp.done && !resp.fast);
  endproperty
  a_slow_on_silence: assert property (p_slow_on_silence)
    else $error("speed not slow after missing acknowledge");

  property p_speed_clear;
    (state_q == S_ERR) || (state_q == S_IDLE && req_valid && req.kind inside {CMD_UNTALK, CMD_UNLISTEN})
      |=> !fast_q;
  endproperty
  a_speed_clear: assert property (p_speed_clear)
    else $error("speed record survived clear event");

  property p_isolation;
    !fast_serial_direction |-> !fast_drive && (serial_data_oe_b == !port_bits.data_low);
  endproperty
  a_isolation: assert property (p_isolation)
    else $error("fast driver on data line with input direction");

  property p_legacy_dir;
    legacy_mode |-> !fast_serial_direction && service_request_fast_clock_oe_b;
  endproperty
  a_legacy_dir: assert property (p_legacy_dir)
    else $error("fast path active in legacy mode");

  property p_ack_window;
    $rose(fast_q) |-> $past(state_q) == S_ACK;
  endproperty
  a_ack_window: assert property (p_ack_window)
    else $error("fast speed recorded outside acknowledge window");

endmodule : serial_bus_host

// ---- testbench/serial_peripheral_model.sv ----
// behavioural serial bus peripheral: presence, fast byte capture, ack, talk
// assumes open-drain wires with pull-ups resolved by the bench
`timescale 1ns/100ps
module serial_peripheral_model (
  input  wire logic       attn_w,
  input  wire logic       fast_w,
  input  wire logic       data_w,
  input  wire logic       present,
  input  wire logic       fast_capable,
  output logic            data_pull,
  output logic            fast_pull,
  output logic      [7:0] addr_seen,
  output logic      [3:0] edge_cnt
);
  // ----------------------------------------------------------------
  // addressing
  // ----------------------------------------------------------------
  initial begin
    data_pull = 1'b0;
    fast_pull = 1'b0;
    addr_seen = 8'h00;
    edge_cnt  = 4'h0;
  end
  always @(negedge attn_w) begin
    edge_cnt = 4'h0;
    if (present) data_pull = 1'b1;
  end
  always @(posedge attn_w) data_pull = 1'b0;
  // data freed once fast clock runs
  always @(negedge fast_w) if (!attn_w) data_pull = 1'b0;
  always @(posedge fast_w) if (!attn_w && edge_cnt < 4'h8) begin
    addr_seen = {data_w, addr_seen[7:1]};
    edge_cnt  = edge_cnt + 4'h1;
    if (edge_cnt == 4'h8 && fast_capable) begin
      #400 fast_pull = 1'b1;
      #32 fast_pull = 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // talking
  // ----------------------------------------------------------------
  // talker sends toward host; clock stands still outside frames
  task automatic send(input logic [7:0] b);
    #7;
    for (int i = 0; i < 8; i++) begin
      fast_pull = 1'b1;
      data_pull = ~b[i];
      #32 fast_pull = 1'b0;
      #32;
    end
    data_pull = 1'b0;
  endtask : send
endmodule : serial_peripheral_model

// ---- testbench/dual_speed_serial_bus_host_test.sv ----
// self-checking bench for the serial bus host
// assumes pull-ups on all bus wires, peripheral model on the far side
`timescale 1ns/100ps
module dual_speed_serial_bus_host_test
  import serial_bus_host_pkg::*;
;
  logic       sys_clk, rst_b, req_valid, legacy_mode, present, fast_capable, dir_seen;
  bus_req_t   req;
  port_bits_t port_bits;
  bus_resp_t  resp, got;
  logic [7:0] timer_reload, ack_window, rx_data, rx_last, addr_seen;
  logic [3:0] edge_cnt;
  logic       req_ready, rx_valid, slow_clk_level, slow_data_level, fast_serial_direction;
  logic       attention_line_oe_b, slow_clock_oe_b, serial_data_oe_b, service_request_fast_clock_oe_b;
  logic       bus_reset_b, data_pull, fast_pull;
  int         failures = 0, checks_done = 0, rx_cnt = 0, lo_run = 0, lo_len = 0;
  wire        fast_w = service_request_fast_clock_oe_b & ~fast_pull;
  wire        data_w = serial_data_oe_b & ~data_pull;

  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  serial_bus_host #(.TIMEOUT_CYC(50)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .resp(resp), .rx_valid(rx_valid), .rx_data(rx_data), .port_bits(port_bits),
    .slow_clk_level(slow_clk_level), .slow_data_level(slow_data_level), .legacy_mode(legacy_mode),
    .timer_reload(timer_reload), .ack_window(ack_window), .fast_serial_direction(fast_serial_direction),
    .attention_line_oe_b(attention_line_oe_b), .slow_clock_in(slow_clock_oe_b), .slow_clock_out(),
    .slow_clock_oe_b(slow_clock_oe_b), .serial_data_in(data_w), .serial_data_out(),
    .serial_data_oe_b(serial_data_oe_b), .service_request_fast_clock(fast_w),
    .service_request_fast_clock_out(), .service_request_fast_clock_oe_b(service_request_fast_clock_oe_b),
    .bus_reset_b(bus_reset_b));
  serial_peripheral_model periph (
    .attn_w(attention_line_oe_b), .fast_w(fast_w), .data_w(data_w), .present(present),
    .fast_capable(fast_capable), .data_pull(data_pull), .fast_pull(fast_pull),
    .addr_seen(addr_seen), .edge_cnt(edge_cnt));

  // ----------------------------------------------------------------
  // clock, watchers, helpers
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (rx_valid === 1'b1) begin
      rx_cnt++;
      rx_last = rx_data;
    end
    if (fast_serial_direction === 1'b1) dir_seen = 1'b1;
    lo_run = (service_request_fast_clock_oe_b === 1'b0) ? lo_run + 1 : 0;
    if (lo_run > lo_len) lo_len = lo_run;
    if (rst_b && fast_serial_direction === 1'b0 && port_bits.data_low === 1'b0)
      check(8'(serial_data_oe_b), 8'h01);
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one request; done awaited under a bound
  task automatic do_req(input bus_cmd_t k, input logic [7:0] a, input logic [7:0] rl, input int lim);
    int n;
    n = 0;
    @(posedge sys_clk);
    req_valid    <= 1'b1;
    req          <= '{kind: k, addr: a};
    timer_reload <= rl;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    got = '0;
    while (got.done !== 1'b1 && n < lim) begin
      @(negedge sys_clk);
      got = resp;
      n++;
    end
    check(8'(got.done), 8'h01);
    check(8'(attention_line_oe_b), 8'h01);
  endtask : do_req
  task automatic conclude();
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check(8'(bus_reset_b), 8'h00);
    check({4'h0, req_ready, resp}, 8'h08);
    @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check(8'(bus_reset_b), 8'h01);
  endtask : t_reset
  task automatic t_slow();
    @(posedge sys_clk);
    port_bits <= '{attn_low: 1'b1, clk_low: 1'b1, data_low: 1'b1};
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check({5'h0, attention_line_oe_b, slow_clock_oe_b, serial_data_oe_b}, 8'h00);
    check({6'h0, slow_clk_level, slow_data_level}, 8'h00);
    @(posedge sys_clk);
    port_bits <= '0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check({6'h0, slow_clk_level, slow_data_level}, 8'h03);
  endtask : t_slow
  // reload below the floor must still give four-cycle halves
  task automatic t_fast();
    present = 1'b1;
    fast_capable = 1'b1;
    lo_len = 0;
    dir_seen = 1'b0;
    do_req(CMD_TALK, 8'hA5, 8'h02, 400);
    check(8'(got), 8'h06);
    check(addr_seen, 8'hA5);
    check(8'(edge_cnt), 8'h08);
    check(8'(lo_len), 8'h04);
    check(8'(dir_seen), 8'h01);
    rx_cnt = 0;
    periph.send(8'h3C);
    repeat (6) @(negedge sys_clk);
    check(8'(rx_cnt), 8'h01);
    check(rx_last, 8'h3C);
  endtask : t_fast
  task automatic t_untalk();
    lo_len = 0;
    do_req(CMD_UNTALK, 8'hA5, 8'h06, 400);
    check(8'(got.timeout), 8'h00);
    check(8'(lo_len), 8'h06);
    rx_cnt = 0;
    periph.send(8'hC3);
    repeat (6) @(negedge sys_clk);
    check(8'(rx_cnt), 8'h00);
  endtask : t_untalk
  task automatic t_slowdev();
    fast_capable = 1'b0;
    do_req(CMD_LISTEN, 8'h5A, 8'h04, 400);
    check(8'(got), 8'h04);
    check(8'(edge_cnt), 8'h08);
  endtask : t_slowdev
  task automatic t_absent();
    present = 1'b0;
    do_req(CMD_UNLISTEN, 8'h09, 8'h04, 200);
    check(8'(got), 8'h05);
  endtask : t_absent
  // legacy: no fast byte and no fast driver turn-on
  task automatic t_legacy();
    present = 1'b1;
    fast_capable = 1'b1;
    dir_seen = 1'b0;
    @(posedge sys_clk);
    legacy_mode <= 1'b1;
    do_req(CMD_LISTEN, 8'h08, 8'h06, 50);
    check(8'(got), 8'h04);
    check(8'(edge_cnt), 8'h00);
    check(8'(dir_seen), 8'h00);
    rx_cnt = 0;
    periph.send(8'h81);
    repeat (6) @(negedge sys_clk);
    check(8'(rx_cnt), 8'h00);
  endtask : t_legacy

  // ----------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req = '0;
    port_bits = '0;
    legacy_mode = 1'b0;
    timer_reload = FAST_RELOAD_DEFAULT;
    ack_window = ACK_WINDOW_DEFAULT;
    present = 1'b0;
    fast_capable = 1'b0;
    t_reset();
    t_slow();
    t_fast();
    t_untalk();
    t_slowdev();
    t_absent();
    t_legacy();
    conclude();
  end
  // whole run is a few hundred cycles; this is far beyond it
  initial begin
    #1000000;
    failures++;
    conclude();
  end
endmodule : dual_speed_serial_bus_host_test
